// File: design/sscfg_consts.vh
`ifndef SSCFG_CONSTS_VH
`define SSCFG_CONSTS_VH
`define SSCFG_PRE_ONES      6'h8
`define SSCFG_CODE_BITS     6'h4
`define SSCFG_LEN_BITS      24
`define SSCFG_HDR_BITS      6'h24
`define SSCFG_CNT_W         24
`define SSCFG_FIFO_W        8
`define SSCFG_FIFO_D        16
`define SSCFG_PROG_BITS     24'd128
`define SSCFG_STARTUP_CYC   4'd4
`define SSCFG_ST_RESET      3'd0
`define SSCFG_ST_PREAMBLE   3'd1
`define SSCFG_ST_HEADER     3'd2
`define SSCFG_ST_LOAD       3'd3
`define SSCFG_ST_STARTUP    3'd4
`define SSCFG_ST_USER       3'd5
`define SSCFG_ST_PWRDN      3'd6
`endif

// File: design/sscfg_fifo.v
`timescale 1ns/1ps
module sscfg_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_sys,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ff;
   reg [AW-1:0]    rd_ff;
   reg [AW:0]      cnt_ff;
   wire            do_wr;
   wire            do_rd;
   assign in_ready  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid = (cnt_ff != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ff];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;
   always @(posedge clk_sys) begin
      if (do_wr) begin
         mem[wr_ff] <= in_data;
      end
   end
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ff  <= {AW{1'b0}};
         rd_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (do_rd) begin
            rd_ff <= rd_ff + 1'b1;
         end
         if (do_wr & ~do_rd) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (do_rd & ~do_wr) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule // sscfg_fifo

// File: design/sscfg_top.v
`timescale 1ns/1ps
`include "sscfg_consts.vh"
// Function
// - Preamble, header and overflow bits are forwarded on serial output.
// - Serial output changes on the falling clock edge, half period later.
// - No configuration begins while reset input is held low.
// - Power-down low suspends the serial port and state machine, keeping stored configuration; the FIFO still drains.
// - While powered down io_enable and pull-ups are off; the done line stays driven low and serial output holds.
// - Power-down release replays the end-of-configuration start-up sequence.
// - Start-up releases user reset, enables outputs, releases done line.
// - Stream has eight ones, 4-bit code, 24-bit length count compared to clocks.
// - User flip-flops stay in reset throughout configuration loading.
module sscfg_top #(
   parameter PROG_BITS = `SSCFG_PROG_BITS
) (
   input  wire                     clk_sys,
   input  wire                     rst,
   input  wire                     config_clock,
   input  wire                     cfg_din,
   input  wire                     reset_n,
   input  wire                     power_down_n,
   output reg                      cfg_dout_ff,
   output wire                     config_done_line_oe,
   output wire                     config_done_line_o,
   input  wire                     config_done_line_i,
   output wire                     init_done,
   output wire                     user_reset,
   output wire                     io_enable,
   output wire                     pullup_enable,
   output wire                     prog_valid,
   input  wire                     prog_ready,
   output wire [`SSCFG_FIFO_W-1:0] prog_data
);
   reg [2:0]  clk_sy_ff;
   reg [2:0]  din_sy_ff;
   reg [2:0]  rstn_sy_ff;
   reg [2:0]  pdn_sy_ff;
   reg        clk_st_ff;
   reg        din_st_ff;
   reg        rstn_st_ff;
   reg        pdn_st_ff;
   reg [2:0]  state_ff;
   reg [2:0]  nxt_state;
   reg [5:0]  hdr_cnt_ff;
   reg [23:0] len_ff;
   reg [23:0] clk_cnt_ff;
   reg [23:0] prog_cnt_ff;
   reg [3:0]  su_cnt_ff;
   reg        fwd_bit_ff;
   reg [7:0]  shift_ff;
   reg [2:0]  bit_cnt_ff;
   reg        push_ff;
   reg [7:0]  word_ff;
   wire       rise;
   wire       fall;
   wire       fifo_in_ready;
   wire       pd_enter;
   wire       pd_exit;
   // Three-stage sampling; change accepted when stages two and three agree
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clk_sy_ff  <= 3'h0;
         din_sy_ff  <= 3'h0;
         rstn_sy_ff <= 3'h0;
         pdn_sy_ff  <= 3'h7;
         clk_st_ff  <= 1'b0;
         din_st_ff  <= 1'b0;
         rstn_st_ff <= 1'b0;
         pdn_st_ff  <= 1'b1;
      end else begin
         clk_sy_ff  <= {clk_sy_ff[1:0], config_clock};
         din_sy_ff  <= {din_sy_ff[1:0], cfg_din};
         rstn_sy_ff <= {rstn_sy_ff[1:0], reset_n};
         pdn_sy_ff  <= {pdn_sy_ff[1:0], power_down_n};
         if (clk_sy_ff[1] == clk_sy_ff[2]) begin
            clk_st_ff <= clk_sy_ff[2];
         end
         if (din_sy_ff[1] == din_sy_ff[2]) begin
            din_st_ff <= din_sy_ff[2];
         end
         if (rstn_sy_ff[1] == rstn_sy_ff[2]) begin
            rstn_st_ff <= rstn_sy_ff[2];
         end
         if (pdn_sy_ff[1] == pdn_sy_ff[2]) begin
            pdn_st_ff <= pdn_sy_ff[2];
         end
      end
   end
   // Edges of the filtered clock; data is filtered alongside, so it aligns
   assign rise = (clk_sy_ff[1] == clk_sy_ff[2]) & clk_sy_ff[2] & ~clk_st_ff;
   assign fall = (clk_sy_ff[1] == clk_sy_ff[2]) & ~clk_sy_ff[2] & clk_st_ff;
   assign pd_enter = ~pdn_st_ff;
   assign pd_exit  = (pdn_sy_ff[1] == pdn_sy_ff[2]) & pdn_sy_ff[2] & ~pdn_st_ff;
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `SSCFG_ST_RESET: begin
            if (rstn_st_ff) begin
               nxt_state = `SSCFG_ST_PREAMBLE;
            end
         end
         `SSCFG_ST_PREAMBLE: begin
            if (rise & ~din_st_ff) begin
               nxt_state = `SSCFG_ST_HEADER;
            end
         end
         `SSCFG_ST_HEADER: begin
            if (rise && hdr_cnt_ff == `SSCFG_HDR_BITS - 1) begin
               nxt_state = `SSCFG_ST_LOAD;
            end
         end
         `SSCFG_ST_LOAD: begin
            if (rise && clk_cnt_ff + 24'h1 >= len_ff) begin
               nxt_state = `SSCFG_ST_STARTUP;
            end
         end
         `SSCFG_ST_STARTUP: begin
            if (su_cnt_ff == `SSCFG_STARTUP_CYC) begin
               nxt_state = `SSCFG_ST_USER;
            end
         end
         `SSCFG_ST_USER: nxt_state = `SSCFG_ST_USER;
         `SSCFG_ST_PWRDN: begin
            if (pd_exit) begin
               nxt_state = `SSCFG_ST_STARTUP;
            end
         end
         default: nxt_state = `SSCFG_ST_RESET;
      endcase
      // The level is still low while the release is seen; exit must win
      if (pd_enter & ~pd_exit) begin
         nxt_state = `SSCFG_ST_PWRDN;
      end
   end
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff    <= `SSCFG_ST_RESET;
         hdr_cnt_ff  <= 6'h0;
         len_ff      <= 24'h0;
         clk_cnt_ff  <= 24'h0;
         prog_cnt_ff <= 24'h0;
         su_cnt_ff   <= 4'h0;
         fwd_bit_ff  <= 1'b1;
         cfg_dout_ff <= 1'b1;
         shift_ff    <= 8'h0;
         bit_cnt_ff  <= 3'h0;
         push_ff     <= 1'b0;
         word_ff     <= 8'h0;
      end else begin
         state_ff <= nxt_state;
         push_ff  <= push_ff & ~fifo_in_ready;
         if (state_ff == `SSCFG_ST_STARTUP) begin
            su_cnt_ff <= su_cnt_ff + 4'h1;
         end else begin
            su_cnt_ff <= 4'h0;
         end
         if (fall & (state_ff != `SSCFG_ST_PWRDN)) begin
            cfg_dout_ff <= fwd_bit_ff;
         end
         if (rise & (state_ff != `SSCFG_ST_PWRDN)) begin
            if (state_ff != `SSCFG_ST_RESET) begin
               clk_cnt_ff <= clk_cnt_ff + 24'h1;
            end
            case (state_ff)
               `SSCFG_ST_PREAMBLE: begin
                  fwd_bit_ff <= din_st_ff;
                  // Index of the bit after the first zero
                  hdr_cnt_ff <= `SSCFG_PRE_ONES + 6'h1;
               end
               `SSCFG_ST_HEADER: begin
                  fwd_bit_ff <= din_st_ff;
                  hdr_cnt_ff <= hdr_cnt_ff + 6'h1;
                  if (hdr_cnt_ff >= `SSCFG_PRE_ONES + `SSCFG_CODE_BITS) begin
                     len_ff <= {len_ff[22:0], din_st_ff};
                  end
               end
               `SSCFG_ST_LOAD: begin
                  if (prog_cnt_ff < PROG_BITS) begin
                     // Own frames are kept; downstream sees ones meanwhile
                     fwd_bit_ff  <= 1'b1;
                     prog_cnt_ff <= prog_cnt_ff + 24'h1;
                     shift_ff    <= {shift_ff[6:0], din_st_ff};
                     bit_cnt_ff  <= bit_cnt_ff + 3'h1;
                     if (bit_cnt_ff == 3'h7) begin
                        push_ff <= 1'b1;
                        word_ff <= {shift_ff[6:0], din_st_ff};
                     end
                  end else begin
                     fwd_bit_ff <= din_st_ff;
                  end
               end
               default: fwd_bit_ff <= 1'b1;
            endcase
         end
      end
   end
   // A word is lost if the 16-word FIFO stays full while two more words arrive
   sscfg_fifo #(
      .WIDTH (`SSCFG_FIFO_W),
      .DEPTH (`SSCFG_FIFO_D),
      .AW    (4)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (push_ff),
      .in_ready  (fifo_in_ready),
      .in_data   (word_ff),
      .out_valid (prog_valid),
      .out_ready (prog_ready),
      .out_data  (prog_data)
   );
   assign init_done  = (state_ff != `SSCFG_ST_RESET);
   assign user_reset = (state_ff != `SSCFG_ST_USER);
   assign io_enable  = (state_ff == `SSCFG_ST_USER);
   assign pullup_enable = (state_ff != `SSCFG_ST_PWRDN);
   // Open drain: pulled low until start-up completes
   assign config_done_line_o  = 1'b0;
   assign config_done_line_oe = (state_ff != `SSCFG_ST_USER);
endmodule // sscfg_top

// File: testbench/sscfg_properties.sv
`timescale 1ns/1ps
module sscfg_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic config_clock,
   input wire logic reset_n,
   input wire logic power_down_n,
   input wire logic cfg_dout_ff,
   input wire logic config_done_line_oe,
   input wire logic init_done,
   input wire logic user_reset,
   input wire logic io_enable,
   input wire logic pullup_enable,
   input wire logic prog_valid,
   input wire logic prog_ready
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   pd_hiz_a: assert property (
      (!power_down_n)[*8] |-> !io_enable && !pullup_enable)
      else $error("outputs live in power-down");
   pd_state_a: assert property (
      !pullup_enable |-> user_reset && !io_enable)
      else $error("logic running in power-down");
   pd_freeze_a: assert property (
      (!power_down_n)[*8] |=> $stable(cfg_dout_ff))
      else $error("serial output moved in power-down");
   cfg_hold_a: assert property (
      !init_done |-> user_reset && !io_enable)
      else $error("user logic freed before start");
   user_pair_a: assert property (
      io_enable == !user_reset)
      else $error("user reset and outputs disagree");
   done_rel_a: assert property (
      io_enable |-> !config_done_line_oe)
      else $error("done line held with outputs on");
   dout_fall_a: assert property (
      $changed(cfg_dout_ff) |-> $past(config_clock, 2) == 1'b0)
      else $error("serial output moved outside low phase");
   resume_run_a: assert property (
      $rose(power_down_n) && reset_n ##1 power_down_n[*8]
      ##1 power_down_n[*8] |-> io_enable)
      else $error("no resume after power-down release");
   cover property ($rose(io_enable));
   cover property (prog_valid && prog_ready);
   cover property ($rose(power_down_n));
endmodule // sscfg_properties

// File: testbench/sscfg_lead_model.sv
`timescale 1ns/1ps
module sscfg_lead_model (
   output logic     config_clock,
   output logic     cfg_din,
   input wire logic cfg_dout_ff
);
   logic seen[$];
   initial begin
      config_clock = 1'b0;
      cfg_din = 1'b1;
   end
   // Clock idles low between bits; only the lead makes edges
   task automatic send(input logic b);
      cfg_din = b;
      #160 config_clock = 1'b1;
      seen.push_back(cfg_dout_ff);
      #160 config_clock = 1'b0;
      cfg_din = ~b; // Stale data must not look valid
   endtask
endmodule // sscfg_lead_model

// File: testbench/test_slave_serial_config_powerdown.sv
`timescale 1ns/1ps
`include "sscfg_consts.vh"
module test_slave_serial_config_powerdown;
   localparam int PB = 16;
   localparam int NB = 36 + PB + 8;
   logic       clk_sys = 0, rst = 1, reset_n = 0;
   logic       power_down_n = 1, prog_ready = 0, d;
   wire        config_clock, cfg_din, cfg_dout_ff, oe, init_done;
   wire        user_reset, io_enable, pullup_enable, prog_valid;
   wire [`SSCFG_FIFO_W-1:0] prog_data;
   logic       bits[NB];
   logic [7:0] got[$];
   int         n_mismatch = 0, comparisons = 0;
   always #20 clk_sys = ~clk_sys;
   sscfg_lead_model lead (.config_clock, .cfg_din, .cfg_dout_ff);
   sscfg_top #(.PROG_BITS(PB)) dut (.clk_sys, .rst, .config_clock,
      .cfg_din, .reset_n, .power_down_n, .cfg_dout_ff,
      .config_done_line_oe(oe), .config_done_line_o(),
      .config_done_line_i(~oe), .init_done, .user_reset, .io_enable,
      .pullup_enable, .prog_valid, .prog_ready, .prog_data);
   task automatic check(input string w, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Program bits stay inside; only header and overflow go on
   function automatic logic fwd(int i);
      return (i < 36 || i >= 36 + PB) ? bits[i] : 1'b1;
   endfunction
   function automatic logic [7:0] pbyte(int k);
      for (int j = 0; j < 8; j++) pbyte[7-j] = bits[36+8*k+j];
   endfunction
   always @(posedge clk_sys) begin
      if (prog_valid === 1'b1 && prog_ready === 1'b1) got.push_back(prog_data);
      #1 prog_ready <= 1'($urandom_range(1, 0));
   end
   initial begin
      #100us;
      n_mismatch++;
      end_sim;
   end
   initial begin
      void'($urandom(32'ha99f));
      for (int i = 0; i < NB; i++) bits[i] = (i < 8) | 1'($urandom);
      bits[8] = 1'b0;
      for (int i = 0; i < 24; i++) bits[12+i] = NB[23-i];
      repeat (3) @(posedge clk_sys);
      #1 rst = 0;
      repeat (20) lead.send(1'b0);
      check("init_done", init_done, 1'b0);
      check("dout_idle", cfg_dout_ff, 1'b1);
      check("done_oe_cfg", oe, 1'b1);
      @(posedge clk_sys) #1 reset_n = 1;
      repeat (4) @(posedge clk_sys);
      #1;
      lead.seen.delete();
      foreach (bits[i]) lead.send(bits[i]);
      for (int i = 1; i < NB; i++) check("dout", lead.seen[i], fwd(i-1));
      check("init_done_hi", init_done, 1'b1);
      for (int t = 0; t < 60 && io_enable !== 1'b1; t++) @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      #1 check("io_enable", io_enable, 1'b1);
      check("user_reset", user_reset, 1'b0);
      check("done_oe", oe, 1'b0);
      check("bytes", got.size(), PB / 8);
      foreach (got[k]) check("byte", got[k], pbyte(k));
      @(posedge clk_sys) #1 power_down_n = 0;
      repeat (8) @(posedge clk_sys);
      #1 check("pullup", pullup_enable, 1'b0);
      check("io_pd", io_enable, 1'b0);
      d = cfg_dout_ff;
      repeat (3) lead.send(~d);
      check("dout_pd", cfg_dout_ff, d);
      @(posedge clk_sys) #1 power_down_n = 1;
      repeat (20) @(posedge clk_sys);
      #1 check("io_resume", io_enable, 1'b1);
      check("pullup_on", pullup_enable, 1'b1);
      end_sim;
   end
endmodule // test_slave_serial_config_powerdown
bind sscfg_top sscfg_properties u_props (.clk_sys, .rst, .config_clock,
   .reset_n, .power_down_n, .cfg_dout_ff, .config_done_line_oe, .init_done,
   .user_reset, .io_enable, .pullup_enable, .prog_valid, .prog_ready);
